// ### cat_cfg.svh
// Constants for the cabinet alarm and timer control block.
// Assumes one 100 MHz clock; slow timing runs off a one-second tick.
// What this block does
// - Any active alarm lights lamp, sounds tone
// - New alarm: 30 s tone, then 2/5 s
// - Silence mutes 15 minutes, then ring-back
// - Eight alarm sources in fixed priority
// - Countdown starts when function keyed on
// - Running timer blinks lamp, steady otherwise
// - Expired countdown switches function off
// - Timer menu fast-blinks selected function lamp
// - Up/down edits quarter-hours, eight hours max
// - Bar shows duration: red, yellow, green
// - Concealed key stores setting, leaves menu
// - Password gates blower with 3-key sequence
// - Password menu fast-blinks red blower lamp
// - Mandatory option removes no-password, default B-H-B
// - Power-up blinks red lamp until keypress
// - Silence key exits every menu
`ifndef CAT_CFG_SVH
`define CAT_CFG_SVH

`define CAT_CLK_PERIOD_NS 10
`define CAT_TICK_NS 1_000_000_000
`define CAT_TICK_CYC (`CAT_TICK_NS / `CAT_CLK_PERIOD_NS)
`define CAT_FAST_DIV 8
`define CAT_CONT_S 30
`define CAT_RING_ON_S 2
`define CAT_RING_PER_S 5
`define CAT_MUTE_MIN 15
`define CAT_MUTE_S (`CAT_MUTE_MIN * 60)
`define CAT_STEP_MIN 15
`define CAT_MAX_MIN 480
`define CAT_MAX_STEPS (`CAT_MAX_MIN / `CAT_STEP_MIN)
`define CAT_STEP_S (`CAT_STEP_MIN * 60)
`define CAT_NUM_FN 4
`define CAT_FN_BLOWER 3
`define CAT_K_BLOWER 0
`define CAT_K_HIDDEN 1
`define CAT_K_LIGHT 2
`define CAT_K_UV 3
`define CAT_K_OUTLET 4
`define CAT_K_SILENCE 5
`define CAT_K_UP 6
`define CAT_K_DOWN 7
`define CAT_ITEM_PW 4
`define CAT_PW_LAST 8
`define CAT_PW_DEFAULT 6

`endif

// ### cat_pkg.sv
// Types shared by the cabinet alarm and timer control block.
// Assumes constants come from cat_cfg.svh.
package cat_pkg;
   typedef logic [7:0] cat_keys_t;
   typedef logic [6:0] cat_src_t;
   typedef logic [3:0] cat_code_t;
   typedef logic [3:0] cat_fn_t;
   typedef logic [7:0] cat_bar_t;
   typedef enum logic [1:0] {AL_IDLE, AL_CONT, AL_RING, AL_MUTE}
      cat_alarm_st_t;
   typedef enum logic [1:0] {M_RUN, M_TIMER, M_PASS} cat_menu_t;
endpackage : cat_pkg

// ### cat_fn_timer.sv
// One function's countdown, in seconds, loaded from quarter-hour steps.
// Assumes tick is a one-cycle pulse once per second on ref_clk.
`timescale 1ns/10ps
`include "cat_cfg.svh"
module cat_fn_timer #(
   parameter int STEP_W = 6,
   parameter int SEC_W = 15
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic tick,
   input wire logic start,
   input wire logic stop,
   input wire logic [STEP_W-1:0] dur_steps,
   output logic running,
   output logic expire
);
   import cat_pkg::*;

   logic [SEC_W-1:0] rem_q;
   logic [SEC_W-1:0] rem_d;
   logic [SEC_W-1:0] load_w;

   assign load_w = SEC_W'(dur_steps * `CAT_STEP_S);
   assign running = (rem_q != '0);
   assign expire = tick && (rem_q == SEC_W'(1)) && !start && !stop;

   always_comb begin
      rem_d = rem_q;
      if (start) begin
         rem_d = load_w;
      end else if (stop) begin
         rem_d = '0;
      end else if (tick && running) begin
         rem_d = rem_q - 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rem_q <= '0;
      end else begin
         rem_q <= rem_d;
      end
   end

   // A zero duration leaves the function untimed
   a_start_loads: assert property (@(posedge ref_clk) disable iff (!arst_n)
      start |=> rem_q == $past(load_w))
      else $error("countdown did not load its duration");
endmodule : cat_fn_timer

// ### cat_ctrl.sv
// Front-panel alarm, silence, countdown and password control.
// Assumes keys, sensors and straps are asynchronous pins, active high.
`timescale 1ns/10ps
`include "cat_cfg.svh"
module cat_ctrl #(
   parameter int TICK_CYC = `CAT_TICK_CYC
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire cat_pkg::cat_keys_t key_pin,
   input wire cat_pkg::cat_src_t src_pin,
   input wire logic menu_req_pin,
   input wire logic [2:0] menu_item_pin,
   input wire logic pw_mand_pin,
   output logic alarm_lamp,
   output logic alarm_tone,
   output cat_pkg::cat_code_t alarm_code,
   output cat_pkg::cat_fn_t fn_out,
   output cat_pkg::cat_fn_t fn_lamp,
   output logic blower_red_lamp,
   output logic bar_red,
   output logic bar_yellow,
   output cat_pkg::cat_bar_t bar_green
);
   import cat_pkg::*;

   localparam int TICK_W = $clog2(TICK_CYC);
   localparam int FAST_CYC = TICK_CYC / `CAT_FAST_DIV;
   localparam int FAST_W = $clog2(FAST_CYC);

   function automatic logic [5:0] f_step(input logic [5:0] v,
      input logic up, input logic dn, input logic [5:0] lo,
      input logic [5:0] hi);
      logic [5:0] r;
      r = v;
      if (up && v < hi) begin
         r = v + 6'h01;
      end else if (dn && v > lo) begin
         r = v - 6'h01;
      end
      return r;
   endfunction : f_step

   function automatic cat_code_t f_prio(input logic [7:0] v);
      cat_code_t c;
      c = 4'h0;
      for (int i = 0; i < 8; i++) begin
         if (v[i]) begin
            c = 4'(8 - i);
         end
      end
      return c;
   endfunction : f_prio

   // ---------------------------------------------------------------
   // Pin synchronisers and key edges
   // ---------------------------------------------------------------
   logic [19:0] sync1_q;
   logic [19:0] sync2_q;
   logic [8:0] prev_q;
   cat_keys_t keys_s;
   cat_keys_t press_w;
   cat_src_t src_s;
   logic menu_go_w;
   logic [2:0] item_s;
   logic mand_s;
   logic any_press_w;

   assign keys_s = sync2_q[7:0];
   assign src_s = sync2_q[14:8];
   assign item_s = sync2_q[18:16];
   assign mand_s = sync2_q[19];
   assign press_w = keys_s & ~prev_q[7:0];
   assign menu_go_w = sync2_q[15] & ~prev_q[8];
   assign any_press_w = |press_w;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= 20'h0_0000;
         sync2_q <= 20'h0_0000;
         prev_q <= 9'h000;
      end else begin
         sync1_q <= {pw_mand_pin, menu_item_pin, menu_req_pin, src_pin,
                     key_pin};
         sync2_q <= sync1_q;
         prev_q <= {sync2_q[15], sync2_q[7:0]};
      end
   end

   // ---------------------------------------------------------------
   // Time base
   // ---------------------------------------------------------------
   logic [TICK_W-1:0] pre_q;
   logic [FAST_W-1:0] fast_cnt_q;
   logic tick_q;
   logic slow_q;
   logic fast_q;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_q <= '0;
         tick_q <= 1'b0;
         slow_q <= 1'b0;
         fast_cnt_q <= '0;
         fast_q <= 1'b0;
      end else begin
         tick_q <= (pre_q == TICK_W'(TICK_CYC - 1));
         pre_q <= (pre_q == TICK_W'(TICK_CYC - 1)) ? '0 : pre_q + 1'b1;
         slow_q <= slow_q ^ tick_q;
         fast_cnt_q <= (fast_cnt_q == FAST_W'(FAST_CYC - 1)) ? '0 :
                       fast_cnt_q + 1'b1;
         fast_q <= fast_q ^ (fast_cnt_q == FAST_W'(FAST_CYC - 1));
      end
   end

   // ---------------------------------------------------------------
   // Alarm sources and tone cadence
   // ---------------------------------------------------------------
   logic por_q;
   logic [7:0] all_w;
   logic [7:0] all_prev_q;
   logic any_w;
   logic new_w;
   logic tone_w;
   cat_alarm_st_t al_q;
   cat_alarm_st_t al_d;
   logic [9:0] sec_q;
   logic [9:0] sec_d;

   assign all_w = {src_s[6:5], por_q, src_s[4:0]};
   assign any_w = |all_w;
   assign new_w = |(all_w & ~all_prev_q);
   assign tone_w = (al_q == AL_CONT) ||
                   (al_q == AL_RING && sec_q < 10'(`CAT_RING_ON_S));

   always_comb begin
      al_d = al_q;
      sec_d = sec_q;
      if (!any_w) begin
         al_d = AL_IDLE;
         sec_d = 10'h000;
      end else if (new_w) begin
         al_d = AL_CONT;
         sec_d = 10'h000;
      end else if (press_w[`CAT_K_SILENCE]) begin
         al_d = AL_MUTE;
         sec_d = 10'h000;
      end else if (tick_q) begin
         sec_d = sec_q + 10'h001;
         case (al_q)
            AL_CONT: begin
               if (sec_q == 10'(`CAT_CONT_S - 1)) begin
                  al_d = AL_RING;
                  sec_d = 10'h000;
               end
            end
            AL_RING: begin
               if (sec_q == 10'(`CAT_RING_PER_S - 1)) begin
                  sec_d = 10'h000;
               end
            end
            AL_MUTE: begin
               if (sec_q == 10'(`CAT_MUTE_S - 1)) begin
                  al_d = AL_RING;
                  sec_d = 10'h000;
               end
            end
            default: begin
               al_d = AL_CONT;
               sec_d = 10'h000;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         al_q <= AL_IDLE;
         sec_q <= 10'h000;
         all_prev_q <= 8'h00;
         por_q <= 1'b1;
      end else begin
         al_q <= al_d;
         sec_q <= sec_d;
         all_prev_q <= all_w;
         if (any_press_w) begin
            por_q <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Menus, timers and blower password
   // ---------------------------------------------------------------
   cat_menu_t menu_q;
   cat_menu_t menu_d;
   logic [1:0] item_q;
   logic [5:0] edit_q;
   logic [5:0] edit_d;
   logic [5:0] dur_q [`CAT_NUM_FN];
   logic [3:0] pw_idx_q;
   logic [2:0] seq_q;
   logic [1:0] seq_n_q;
   cat_fn_t on_q;
   cat_fn_t tgl_w;
   cat_fn_t run_w;
   cat_fn_t exp_w;
   logic run_mode_w;
   logic bh_w;
   logic match_w;
   logic blow_tgl_w;
   logic st_tim_w;
   logic st_pw_w;
   logic [5:0] pw_lo_w;

   assign run_mode_w = (menu_q == M_RUN);
   assign bh_w = run_mode_w &&
                 (press_w[`CAT_K_BLOWER] || press_w[`CAT_K_HIDDEN]);
   assign match_w = bh_w && seq_n_q == 2'h2 &&
                    {seq_q[1:0], press_w[`CAT_K_BLOWER]} ==
                    3'(pw_idx_q - 4'h1);
   assign blow_tgl_w = (pw_idx_q == 4'h0) ?
                       run_mode_w && press_w[`CAT_K_BLOWER] : match_w;
   assign tgl_w = run_mode_w ? {blow_tgl_w, press_w[`CAT_K_UV],
      press_w[`CAT_K_LIGHT], press_w[`CAT_K_OUTLET]} : 4'h0;
   assign st_tim_w = menu_q == M_TIMER && press_w[`CAT_K_HIDDEN];
   assign st_pw_w = menu_q == M_PASS && press_w[`CAT_K_HIDDEN];
   assign pw_lo_w = mand_s ? 6'h01 : 6'h00;

   for (genvar f = 0; f < `CAT_NUM_FN; f++) begin : g_fn
      cat_fn_timer u_tim (
         .ref_clk(ref_clk),
         .arst_n(arst_n),
         .tick(tick_q),
         .start(tgl_w[f] & ~on_q[f]),
         .stop(tgl_w[f] & on_q[f]),
         .dur_steps(dur_q[f]),
         .running(run_w[f]),
         .expire(exp_w[f])
      );
   end

   always_comb begin
      menu_d = menu_q;
      edit_d = edit_q;
      if (!run_mode_w && press_w[`CAT_K_SILENCE]) begin
         menu_d = M_RUN;
      end else begin
         case (menu_q)
            M_RUN: begin
               if (menu_go_w && item_s < 3'(`CAT_ITEM_PW)) begin
                  menu_d = M_TIMER;
                  edit_d = dur_q[item_s[1:0]];
               end else if (menu_go_w && item_s == 3'(`CAT_ITEM_PW)) begin
                  menu_d = M_PASS;
                  edit_d = {2'h0, pw_idx_q};
               end
            end
            M_TIMER: begin
               edit_d = f_step(edit_q, press_w[`CAT_K_UP],
                  press_w[`CAT_K_DOWN], 6'h00, 6'(`CAT_MAX_STEPS));
               menu_d = st_tim_w ? M_RUN : M_TIMER;
            end
            M_PASS: begin
               edit_d = f_step(edit_q, press_w[`CAT_K_UP],
                  press_w[`CAT_K_DOWN], pw_lo_w, 6'(`CAT_PW_LAST));
               menu_d = st_pw_w ? M_RUN : M_PASS;
            end
            default: menu_d = M_RUN;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         menu_q <= M_RUN;
         item_q <= 2'h0;
         edit_q <= 6'h00;
         pw_idx_q <= 4'h0;
         seq_q <= 3'h0;
         seq_n_q <= 2'h0;
         on_q <= 4'h0;
         for (int i = 0; i < `CAT_NUM_FN; i++) begin
            dur_q[i] <= 6'h00;
         end
      end else begin
         menu_q <= menu_d;
         edit_q <= edit_d;
         if (run_mode_w && menu_go_w) begin
            item_q <= item_s[1:0];
         end
         if (st_tim_w) begin
            dur_q[item_q] <= edit_q;
         end
         if (st_pw_w) begin
            pw_idx_q <= edit_q[3:0];
         end else if (mand_s && pw_idx_q == 4'h0) begin
            pw_idx_q <= 4'(`CAT_PW_DEFAULT);
         end
         if (bh_w) begin
            seq_q <= {seq_q[1:0], press_w[`CAT_K_BLOWER]};
            seq_n_q <= match_w ? 2'h0 :
                       (seq_n_q == 2'h2 ? 2'h2 : seq_n_q + 2'h1);
         end
         on_q <= (on_q ^ tgl_w) & ~exp_w;
      end
   end

   // ---------------------------------------------------------------
   // Output registers
   // ---------------------------------------------------------------
   cat_fn_t lamp_w;
   logic [3:0] hours_w;

   assign hours_w = edit_q[5:2];
   for (genvar f = 0; f < `CAT_NUM_FN; f++) begin : g_lamp
      // blink while counting; fast when selected
      assign lamp_w[f] = (menu_q == M_TIMER && item_q == 2'(f)) ? fast_q :
                         on_q[f] & (run_w[f] ? slow_q : 1'b1);
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         alarm_lamp <= 1'b0;
         alarm_tone <= 1'b0;
         alarm_code <= 4'h0;
         fn_out <= 4'h0;
         fn_lamp <= 4'h0;
         blower_red_lamp <= 1'b0;
         bar_red <= 1'b0;
         bar_yellow <= 1'b0;
         bar_green <= 8'h00;
      end else begin
         // steady for real sources, blink power-up
         alarm_lamp <= (|src_s) | (por_q & slow_q);
         alarm_tone <= tone_w;
         alarm_code <= f_prio(all_w);
         fn_out <= on_q;
         fn_lamp <= lamp_w;
         blower_red_lamp <= (menu_q == M_PASS) & fast_q;
         bar_red <= (menu_q == M_TIMER) & edit_q[0];
         bar_yellow <= (menu_q == M_TIMER) & edit_q[1];
         for (int i = 0; i < 8; i++) begin
            bar_green[i] <= (menu_q == M_TIMER) && (hours_w > 4'(i));
         end
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence s_sil_in_alarm;
      press_w[`CAT_K_SILENCE] && any_w && !new_w;
   endsequence

   a_lamp_on_alarm: assert property (|src_s |=> alarm_lamp)
      else $error("alarm lamp dark with source active");
   a_tone_cont: assert property (al_q == AL_CONT |=> alarm_tone)
      else $error("tone missing in continuous phase");
   a_cont_ends: assert property (al_q == AL_CONT && tick_q &&
      sec_q == 10'd29 && any_w && !new_w && !press_w[5]
      |=> al_q == AL_RING && sec_q == 10'h000)
      else $error("continuous phase not 30 s");
   a_silence_mutes: assert property (s_sil_in_alarm
      |=> al_q == AL_MUTE ##1 !alarm_tone)
      else $error("silence did not mute");
   a_prio_top: assert property (src_s[6] |=> alarm_code == 4'h1)
      else $error("top source not reported");
   a_expire_off: assert property (|exp_w |=>
      (on_q & $past(exp_w)) == 4'h0)
      else $error("expired function stays on");
   a_edit_limit: assert property (menu_q == M_TIMER
      |-> edit_q <= 6'h20)
      else $error("duration above 8 hours");
   a_store_exit: assert property (st_tim_w && !press_w[5]
      |=> menu_q == M_RUN && dur_q[item_q] == $past(edit_q))
      else $error("setting not stored");
   a_pw_blocks: assert property (pw_idx_q != 4'h0 && !match_w &&
      run_mode_w |=> on_q[3] == $past(on_q[3]) || $past(exp_w[3]))
      else $error("blower toggled without password");
   a_mand_default: assert property (mand_s && pw_idx_q == 4'h0 &&
      !st_pw_w |=> pw_idx_q == 4'h6)
      else $error("mandatory password not defaulted");
   a_por_ack: assert property (any_press_w |=> !por_q)
      else $error("power-up not acknowledged");
   a_sil_exit: assert property (!run_mode_w && press_w[5]
      |=> menu_q == M_RUN)
      else $error("silence did not leave menu");
endmodule : cat_ctrl

// ### cat_panel_model.sv
// Operator panel and sensor stand-in for the cabinet control block.
// Assumes the bench calls its tasks; pins change 1 ns after a rising edge.
`timescale 1ns/10ps
`include "cat_cfg.svh"
module cat_panel_model (
   input wire logic ref_clk,
   output cat_pkg::cat_keys_t key_pin,
   output cat_pkg::cat_src_t src_pin,
   output logic menu_req_pin,
   output logic [2:0] menu_item_pin,
   output logic pw_mand_pin
);
   import cat_pkg::*;
   initial begin
      key_pin = 8'h00;
      src_pin = 7'h00;
      menu_req_pin = 1'b0;
      menu_item_pin = 3'h0;
      pw_mand_pin = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : hold
   // Four edges down, four up: well clear of the 2-cycle release gap
   task automatic press(input int k);
      hold(1);
      key_pin[k] = 1'b1;
      hold(4);
      key_pin[k] = 1'b0;
      hold(4);
   endtask : press
   task automatic set_src(input cat_src_t v);
      hold(1);
      src_pin = v;
   endtask : set_src
   task automatic set_strap(input logic v);
      hold(1);
      pw_mand_pin = v;
   endtask : set_strap
   // Item settles a cycle before the request edge is seen
   task automatic open_menu(input logic [2:0] item);
      hold(1);
      menu_item_pin = item;
      hold(1);
      menu_req_pin = 1'b1;
      hold(4);
      menu_req_pin = 1'b0;
      hold(4);
   endtask : open_menu
   task automatic enter_code(input logic [2:0] c);
      for (int i = 2; i >= 0; i--) begin
         press(c[i] ? `CAT_K_BLOWER : `CAT_K_HIDDEN);
      end
   endtask : enter_code
endmodule : cat_panel_model

// ### tb_cabinet_alarm_timer_control.sv
// Self-checking bench for the cabinet alarm and timer control block.
// Assumes cat_ctrl with a shortened second of 16 clocks.
`timescale 1ns/10ps
`include "cat_cfg.svh"
module tb_cabinet_alarm_timer_control;
   import cat_pkg::*;
   localparam int TK = 16;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   cat_keys_t key_pin;
   cat_src_t src_pin;
   logic menu_req_pin, pw_mand_pin, alarm_lamp, alarm_tone;
   logic [2:0] menu_item_pin;
   logic blower_red_lamp, bar_red, bar_yellow;
   cat_code_t alarm_code;
   cat_fn_t fn_out, fn_lamp;
   cat_bar_t bar_green;
   int error_cnt = 0;
   int n_compared = 0;
   int c;
   always #5 ref_clk = ~ref_clk;
   cat_panel_model u_cat_panel_model (.ref_clk(ref_clk),
      .key_pin(key_pin), .src_pin(src_pin), .menu_req_pin(menu_req_pin),
      .menu_item_pin(menu_item_pin), .pw_mand_pin(pw_mand_pin));
   cat_ctrl #(.TICK_CYC(TK)) u_cat_ctrl (.ref_clk(ref_clk),
      .arst_n(arst_n), .key_pin(key_pin), .src_pin(src_pin),
      .menu_req_pin(menu_req_pin), .menu_item_pin(menu_item_pin),
      .pw_mand_pin(pw_mand_pin), .alarm_lamp(alarm_lamp),
      .alarm_tone(alarm_tone), .alarm_code(alarm_code), .fn_out(fn_out),
      .fn_lamp(fn_lamp), .blower_red_lamp(blower_red_lamp),
      .bar_red(bar_red), .bar_yellow(bar_yellow), .bar_green(bar_green));
   // ----------------------------------------------------------------
   // Compare and sampling helpers
   // ----------------------------------------------------------------
   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit
   task automatic chk_vec(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_vec
   task automatic chk_cnt(input string nm, input int lo, input int hi,
      input int g);
      n_compared++;
      if (g < lo || g > hi) begin
         error_cnt++;
         $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask : chk_cnt
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : wt
   task automatic key(input int k);
      u_cat_panel_model.press(k);
   endtask : key
   // One sample per second, so any 5 s of ring-back holds 2 on-samples
   task automatic tone_cnt(input int n, output int cnt);
      cnt = 0;
      repeat (n) begin
         wt(TK);
         if (alarm_tone === 1'b1) cnt++;
      end
   endtask : tone_cnt
   function automatic logic pick(input int sel);
      case (sel)
         0: return alarm_lamp;
         1: return fn_lamp[2];
         2: return blower_red_lamp;
         default: return fn_lamp[1];
      endcase
   endfunction : pick
   task automatic toggles(input int sel, input int cyc, output int cnt);
      logic prev;
      cnt = 0;
      prev = pick(sel);
      repeat (cyc) begin
         wt(1);
         if (pick(sel) !== prev) cnt++;
         prev = pick(sel);
      end
   endtask : toggles
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_powerup();
      wt(10);
      chk_vec("code", 8'h03, {4'h0, alarm_code});
      chk_bit("tone", 1'b1, alarm_tone);
      toggles(0, 4 * TK, c);
      chk_cnt("lamp blink", 2, 5, c);
      key(`CAT_K_SILENCE);
      wt(3);
      chk_vec("code", 8'h00, {4'h0, alarm_code});
      chk_bit("lamp", 1'b0, alarm_lamp);
      $display("power-up done");
   endtask : t_powerup
   task automatic t_cadence();
      u_cat_panel_model.set_src(7'h01);
      wt(6);
      chk_vec("code", 8'h08, {4'h0, alarm_code});
      chk_bit("lamp", 1'b1, alarm_lamp);
      tone_cnt(28, c);
      chk_cnt("tone cont", 28, 28, c);
      wt(4 * TK);
      tone_cnt(10, c);
      chk_cnt("tone ring", 4, 4, c);
      key(`CAT_K_SILENCE);
      chk_bit("lamp", 1'b1, alarm_lamp);
      tone_cnt(`CAT_MUTE_S - 8, c);
      chk_cnt("tone muted", 0, 0, c);
      wt(16 * TK);
      tone_cnt(10, c);
      chk_cnt("tone ringback", 4, 4, c);
      $display("cadence done");
   endtask : t_cadence
   task automatic t_priority();
      for (int b = 0; b < 7; b++) begin
         u_cat_panel_model.set_src((7'h01 << b) | 7'h01);
         wt(6);
         chk_vec("code", (b >= 5) ? 7 - b : 8 - b, {4'h0, alarm_code});
      end
      u_cat_panel_model.set_src(7'h7F);
      wt(6);
      chk_vec("code", 8'h01, {4'h0, alarm_code});
      u_cat_panel_model.set_src(7'h00);
      wt(6);
      chk_vec("code", 8'h00, {4'h0, alarm_code});
      chk_bit("lamp", 1'b0, alarm_lamp);
      chk_bit("tone", 1'b0, alarm_tone);
      $display("priority done");
   endtask : t_priority
   task automatic t_timer();
      u_cat_panel_model.open_menu(3'h2);
      toggles(1, TK, c);
      chk_cnt("uv fast", 6, 16, c);
      repeat (5) key(`CAT_K_UP);
      wt(2);
      chk_vec("bar", {6'h00, 2'h1}, {6'h00, bar_yellow, bar_red});
      chk_vec("green", 8'h01, bar_green);
      repeat (30) key(`CAT_K_UP);
      wt(2);
      chk_vec("bar", 8'h00, {6'h00, bar_yellow, bar_red});
      chk_vec("green", 8'hFF, bar_green);
      repeat (31) key(`CAT_K_DOWN);
      wt(2);
      chk_vec("bar", 8'h01, {6'h00, bar_yellow, bar_red});
      key(`CAT_K_HIDDEN);
      chk_bit("bar red", 1'b0, bar_red);
      key(`CAT_K_UV);
      chk_bit("uv on", 1'b1, fn_out[2]);
      toggles(1, 3 * TK, c);
      chk_cnt("uv slow", 1, 4, c);
      wt(`CAT_STEP_S * TK - 8 * TK);
      chk_bit("uv on", 1'b1, fn_out[2]);
      wt(8 * TK);
      chk_bit("uv off", 1'b0, fn_out[2]);
      key(`CAT_K_LIGHT);
      toggles(3, 3 * TK, c);
      chk_cnt("light steady", 0, 0, c);
      chk_bit("light", 1'b1, fn_lamp[1]);
      key(`CAT_K_LIGHT);
      chk_bit("light off", 1'b0, fn_out[1]);
      key(`CAT_K_OUTLET);
      chk_bit("outlet on", 1'b1, fn_out[0]);
      chk_bit("outlet lamp", 1'b1, fn_lamp[0]);
      key(`CAT_K_OUTLET);
      chk_bit("outlet off", 1'b0, fn_out[0]);
      $display("timer done");
   endtask : t_timer
   task automatic t_exit();
      u_cat_panel_model.open_menu(3'h1);
      toggles(3, TK, c);
      chk_cnt("light fast", 6, 16, c);
      key(`CAT_K_UP);
      wt(2);
      chk_bit("bar red", 1'b1, bar_red);
      key(`CAT_K_SILENCE);
      chk_bit("bar red", 1'b0, bar_red);
      u_cat_panel_model.open_menu(3'h1);
      wt(2);
      chk_bit("bar red", 1'b0, bar_red);
      key(`CAT_K_SILENCE);
      $display("menu exit done");
   endtask : t_exit
   task automatic t_password();
      u_cat_panel_model.set_strap(1'b1);
      wt(4);
      key(`CAT_K_BLOWER);
      chk_bit("blower", 1'b0, fn_out[3]);
      u_cat_panel_model.enter_code(3'b101);
      chk_bit("blower", 1'b1, fn_out[3]);
      chk_bit("blower lamp", 1'b1, fn_lamp[3]);
      u_cat_panel_model.open_menu(3'h4);
      toggles(2, TK, c);
      chk_cnt("pw lamp", 6, 16, c);
      key(`CAT_K_DOWN);
      key(`CAT_K_HIDDEN);
      chk_bit("pw lamp", 1'b0, blower_red_lamp);
      u_cat_panel_model.enter_code(3'b100);
      chk_bit("blower", 1'b0, fn_out[3]);
      $display("password done");
   endtask : t_password
   // ----------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize
   // Tests need about 31k clocks; allow roughly two and a half times
   initial begin
      #800_000;
      error_cnt++;
      $display("[ERR] watchdog expected finish seen timeout");
      summarize();
   end
   initial begin
      wt(6);
      arst_n = 1'b1;
      t_powerup();
      t_cadence();
      t_priority();
      t_timer();
      t_exit();
      t_password();
      summarize();
   end
endmodule : tb_cabinet_alarm_timer_control
